// ===== brpc_pkg.sv
// Overview of operation
// - entering D3hot stops secondary clocks low when the clock-stop enable input allows
// - writes requesting D1 or D2 are ignored; state keeps its previous value
// - D3hot to D0 restarts clocks and does a chip reset without secondary reset
// - leaving D3cold runs the normal power-up reset sequence
// - power-management events from downstream are never forwarded
// - primary reset tri-states both buses, resets chip and registers
// - primary and secondary reset inputs are synchronised internally
// - configuration access refused for 16 clocks after primary reset release
// - secondary reset output held while primary reset is asserted
// - secondary reset control bit holds secondary reset until cleared by write
// - secondary reset tri-states all secondary control signals including grants
// - secondary address/data, command/byte enables and parity driven low in bit- or pin-driven secondary reset
// - secondary reset clears posted-write and delayed-transaction buffers
// - configuration accesses still answered during bit-driven secondary reset
// - chip reset bit resets state, tri-states, asserts secondary reset, sets control bit
// - chip reset holds until bit cleared and mask loaded; self-clears within 20 clocks
// - accesses during chip reset are answered with an error; only a write clearing the secondary reset bit takes effect
// - active-low hot-swap event output signals insertion or pending extraction
// - hot-swap LED output shows readiness for insertion or removal
package brpc_pkg;
    // register byte offsets
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_PMCSR = 12'h004;
    localparam logic [11:0] ADDR_DIAG = 12'h008;
    localparam logic [11:0] ADDR_HOTSWAP = 12'h00C;
    localparam logic [11:0] ADDR_STATUS = 12'h010;
    // field positions
    localparam int CTRL_SEC_RST_BIT = 0;
    localparam int DIAG_CHIP_RST_BIT = 0;
    localparam int HS_EVENT_BIT = 0;
    localparam int HS_LED_BIT = 1;
    localparam int HS_EVENT_CLR_BIT = 2;
    // power states
    localparam logic [1:0] PS_D0 = 2'h0;
    localparam logic [1:0] PS_D1 = 2'h1;
    localparam logic [1:0] PS_D2 = 2'h2;
    localparam logic [1:0] PS_D3HOT = 2'h3;
    // timing counts
    localparam int CFG_HOLDOFF_CLKS = 16;
    localparam int CHIP_RST_CLEAR_MAX_CLKS = 20;
    localparam int CHIP_RST_CLEAR_CLKS = 4;
    localparam int CLK_MASK_BITS = 16;
endpackage : brpc_pkg

// ===== brpc_sync.sv
`timescale 1ns/1ps
// two-flop level synchroniser, reset to the asserted level
module brpc_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            meta_q <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : brpc_sync

// ===== brpc_top.sv
`timescale 1ns/1ps
module brpc_top #(
    parameter int HOLDOFF = brpc_pkg::CFG_HOLDOFF_CLKS,
    parameter int MASK_BITS = brpc_pkg::CLK_MASK_BITS
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // asynchronous reset pins and straps
    input wire logic prim_reset_n_in,
    input wire logic sec_reset_pin_n_in,
    input wire logic sec_clock_stop_enable_in,
    input wire logic clk_mask_bit_in,
    input wire logic clk_mask_valid_in,
    input wire logic sec_clk_free_in,
    input wire logic pme_n_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // secondary bus
    output logic sec_reset_n_out,
    output logic secondary_clock_out,
    output logic prim_bus_oe_out,
    output logic sec_ctrl_oe_out,
    output logic sec_data_oe_out,
    output logic [31:0] secondary_addr_data_out,
    output logic [3:0] secondary_cmd_byte_en_n_out,
    output logic secondary_parity_out,
    output logic buffer_flush_out,
    // hot swap
    output logic hot_swap_event_n_out,
    output logic swap_ready_led_out
);
    // ****************************************
    // reset synchronisation
    // ****************************************
    logic prim_rst_sync;
    logic sec_pin_rst_sync;
    logic prim_rst_n_nonsync;
    logic sec_rst_n_nonsync;

    assign prim_rst_n_nonsync = prim_reset_n_in;
    assign sec_rst_n_nonsync = sec_reset_pin_n_in;

    brpc_sync #(.RESET_VAL(1'b0)) u_prim_sync (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .async_in(prim_rst_n_nonsync),
        .sync_out(prim_rst_sync)
    );

    brpc_sync #(.RESET_VAL(1'b0)) u_sec_sync (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .async_in(sec_rst_n_nonsync),
        .sync_out(sec_pin_rst_sync)
    );

    // active-high primary reset, seen either from the system reset or the pin
    logic prim_rst;
    assign prim_rst = !reset_n_in || !prim_rst_sync;

    // ****************************************
    // state
    // ****************************************
    typedef enum {CR_IDLE, CR_WAIT_CLEAR, CR_DONE} brpc_chip_state_t;
    brpc_chip_state_t cr_state_q;
    logic sec_rst_bit_q;
    logic chip_rst_bit_q;
    logic [1:0] pwr_state_q;
    logic [4:0] holdoff_q;
    logic [4:0] clear_cnt_q;
    logic [$clog2(MASK_BITS+1)-1:0] mask_cnt_q;
    logic [MASK_BITS-1:0] clk_mask_q;
    logic mask_loaded_q;
    logic hs_event_q;
    logic hs_led_q;
    logic chip_rst_pulse_q;

    logic wr_en;
    logic rd_en;
    logic accessible;
    logic d3_to_d0;

    // ****************************************
    // access gating
    // ****************************************
    // refused accesses set up outside primary reset still complete on the bus with an error so the master never hangs
    // the secondary reset bit is deliberately absent here so software can still reach us
    assign accessible = (holdoff_q == 5'h00) && (cr_state_q == CR_IDLE) && !chip_rst_pulse_q;
    assign wr_en = psel_in && penable_in && pwrite_in && pready_out && accessible;
    assign rd_en = psel_in && penable_in && !pwrite_in && accessible;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    assign d3_to_d0 = wr_en && hit(paddr_in, brpc_pkg::ADDR_PMCSR) &&
        pwr_state_q == brpc_pkg::PS_D3HOT && pwdata_in[1:0] == brpc_pkg::PS_D0;

    // ****************************************
    // configuration hold-off after primary reset
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        if (prim_rst) begin
            holdoff_q <= 5'(HOLDOFF);
        end else if (holdoff_q != 5'h00) begin
            holdoff_q <= holdoff_q - 5'h01;
        end
    end

    // ****************************************
    // apb answer
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        if (prim_rst) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
        end else begin
            pready_out <= psel_in && !penable_in;
            pslverr_out <= psel_in && !penable_in && !accessible;
            prdata_out <= 32'h0000_0000;
            if (psel_in && !penable_in && !pwrite_in && accessible) begin
                case (paddr_in)
                    brpc_pkg::ADDR_CTRL: prdata_out[brpc_pkg::CTRL_SEC_RST_BIT] <= sec_rst_bit_q;
                    brpc_pkg::ADDR_PMCSR: prdata_out[1:0] <= pwr_state_q;
                    brpc_pkg::ADDR_DIAG: prdata_out[brpc_pkg::DIAG_CHIP_RST_BIT] <= chip_rst_bit_q;
                    brpc_pkg::ADDR_HOTSWAP: begin
                        prdata_out[brpc_pkg::HS_EVENT_BIT] <= hs_event_q;
                        prdata_out[brpc_pkg::HS_LED_BIT] <= hs_led_q;
                    end
                    brpc_pkg::ADDR_STATUS: begin
                        // loaded flag sits just above the widest mask, whatever MASK_BITS is
                        prdata_out[brpc_pkg::CLK_MASK_BITS] <= mask_loaded_q;
                        prdata_out[MASK_BITS-1:0] <= clk_mask_q;
                    end
                    default: prdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************
    // power state
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        if (prim_rst || cr_state_q != CR_IDLE) begin
            pwr_state_q <= brpc_pkg::PS_D0;
        end else if (wr_en && hit(paddr_in, brpc_pkg::ADDR_PMCSR)) begin
            // D1 and D2 are not implemented, so such writes leave the field alone
            if (pwdata_in[1:0] == brpc_pkg::PS_D0 || pwdata_in[1:0] == brpc_pkg::PS_D3HOT) begin
                pwr_state_q <= pwdata_in[1:0];
            end
        end
    end

    // one-cycle internal chip reset on D3hot to D0, clears the secondary reset bit without asserting secondary reset
    always_ff @(posedge sys_clk_in) begin
        if (prim_rst) begin
            chip_rst_pulse_q <= 1'b0;
        end else begin
            chip_rst_pulse_q <= d3_to_d0;
        end
    end

    // ****************************************
    // secondary reset bit and chip reset sequence
    // ****************************************
    logic chip_rst_active;
    assign chip_rst_active = (cr_state_q != CR_IDLE);

    always_ff @(posedge sys_clk_in) begin
        if (prim_rst) begin
            sec_rst_bit_q <= 1'b0;
        end else if (wr_en && hit(paddr_in, brpc_pkg::ADDR_DIAG) && pwdata_in[brpc_pkg::DIAG_CHIP_RST_BIT]) begin
            sec_rst_bit_q <= 1'b1;
        end else if (chip_rst_pulse_q) begin
            sec_rst_bit_q <= 1'b0;
        end else if (cr_state_q == CR_WAIT_CLEAR) begin
            // only clearing is taken while the chip reset is pending
            if (psel_in && penable_in && pwrite_in && pready_out && hit(paddr_in, brpc_pkg::ADDR_CTRL) &&
                !pwdata_in[brpc_pkg::CTRL_SEC_RST_BIT]) begin
                sec_rst_bit_q <= 1'b0;
            end
        end else if (wr_en && hit(paddr_in, brpc_pkg::ADDR_CTRL)) begin
            sec_rst_bit_q <= pwdata_in[brpc_pkg::CTRL_SEC_RST_BIT];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (prim_rst) begin
            cr_state_q <= CR_IDLE;
            chip_rst_bit_q <= 1'b0;
            clear_cnt_q <= 5'h00;
        end else begin
            case (cr_state_q)
                CR_IDLE: begin
                    if (wr_en && hit(paddr_in, brpc_pkg::ADDR_DIAG) && pwdata_in[brpc_pkg::DIAG_CHIP_RST_BIT]) begin
                        chip_rst_bit_q <= 1'b1;
                        cr_state_q <= CR_WAIT_CLEAR;
                    end
                end
                CR_WAIT_CLEAR: begin
                    if (!sec_rst_bit_q && mask_loaded_q) begin
                        clear_cnt_q <= 5'(brpc_pkg::CHIP_RST_CLEAR_CLKS);
                        cr_state_q <= CR_DONE;
                    end
                end
                CR_DONE: begin
                    if (clear_cnt_q == 5'h00) begin
                        chip_rst_bit_q <= 1'b0;
                        cr_state_q <= CR_IDLE;
                    end else begin
                        clear_cnt_q <= clear_cnt_q - 5'h01;
                    end
                end
                default: cr_state_q <= CR_IDLE;
            endcase
        end
    end

    // serial clock mask: shifted in after a chip reset begins
    always_ff @(posedge sys_clk_in) begin
        if (prim_rst || (cr_state_q == CR_IDLE && !(wr_en && hit(paddr_in, brpc_pkg::ADDR_DIAG)))) begin
            if (prim_rst) begin
                clk_mask_q <= '0;
            end
            mask_cnt_q <= '0;
            mask_loaded_q <= prim_rst ? 1'b0 : mask_loaded_q;
        end else if (cr_state_q == CR_WAIT_CLEAR && !mask_loaded_q && clk_mask_valid_in) begin
            clk_mask_q <= {clk_mask_q[MASK_BITS-2:0], clk_mask_bit_in};
            mask_cnt_q <= mask_cnt_q + 1'b1;
            if (mask_cnt_q == ($bits(mask_cnt_q))'(MASK_BITS - 1)) begin
                mask_loaded_q <= 1'b1;
            end
        end else if (cr_state_q == CR_IDLE) begin
            mask_loaded_q <= 1'b0;
        end
    end

    // ****************************************
    // secondary bus drive
    // ****************************************
    logic sec_rst_any;
    assign sec_rst_any = prim_rst || sec_rst_bit_q || chip_rst_active || !sec_pin_rst_sync;

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            sec_reset_n_out <= 1'b0;
            prim_bus_oe_out <= 1'b0;
            sec_ctrl_oe_out <= 1'b0;
            sec_data_oe_out <= 1'b0;
            secondary_addr_data_out <= 32'h0000_0000;
            secondary_cmd_byte_en_n_out <= 4'h0;
            secondary_parity_out <= 1'b0;
            buffer_flush_out <= 1'b1;
        end else begin
            sec_reset_n_out <= !(prim_rst || sec_rst_bit_q || chip_rst_active);
            prim_bus_oe_out <= !(prim_rst || chip_rst_active || chip_rst_pulse_q);
            sec_ctrl_oe_out <= !sec_rst_any;
            // data lines are parked low and driven during bit or pin secondary reset, tri-stated in primary reset or bit-driven chip reset
            sec_data_oe_out <= !(prim_rst || chip_rst_active);
            secondary_addr_data_out <= 32'h0000_0000;
            secondary_cmd_byte_en_n_out <= 4'h0;
            secondary_parity_out <= 1'b0;
            buffer_flush_out <= sec_rst_any || chip_rst_pulse_q;
        end
    end

    // ****************************************
    // secondary clock gating
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            secondary_clock_out <= 1'b0;
        end else if (pwr_state_q == brpc_pkg::PS_D3HOT && sec_clock_stop_enable_in) begin
            secondary_clock_out <= 1'b0;
        end else begin
            secondary_clock_out <= sec_clk_free_in;
        end
    end

    // ****************************************
    // hot swap
    // ****************************************
    // downstream pme_n is deliberately left unconnected inside the bridge
    always_ff @(posedge sys_clk_in) begin
        if (prim_rst || chip_rst_active || chip_rst_pulse_q) begin
            // chip reset of either kind returns the hot swap registers to defaults
            hs_event_q <= 1'b0;
            hs_led_q <= 1'b0;
            hot_swap_event_n_out <= 1'b1;
            swap_ready_led_out <= 1'b0;
        end else begin
            if (wr_en && hit(paddr_in, brpc_pkg::ADDR_HOTSWAP)) begin
                hs_led_q <= pwdata_in[brpc_pkg::HS_LED_BIT];
                if (pwdata_in[brpc_pkg::HS_EVENT_BIT]) begin
                    hs_event_q <= 1'b1;
                end else if (pwdata_in[brpc_pkg::HS_EVENT_CLR_BIT]) begin
                    hs_event_q <= 1'b0;
                end
            end
            hot_swap_event_n_out <= !hs_event_q;
            swap_ready_led_out <= hs_led_q;
        end
    end

    logic unused_ok;
    assign unused_ok = pme_n_in ^ rd_en;
endmodule : brpc_top

// ===== brpc_far_model.sv
`timescale 1ns/1ps
// *****
// secondary side: free clock, serial clock mask, downstream events
// *****
module brpc_far_model #(
    parameter int BITS = 4
) (
    input wire logic sys_clk_in,
    input wire logic go_in,
    input wire logic [15:0] pat_in,
    output logic sec_clk_free_out,
    output logic clk_mask_bit_out,
    output logic clk_mask_valid_out,
    output logic pme_n_out
);
    int n_q = 0;
    logic free_q = 1'b0;
    logic pme_q = 1'b1;
    always_ff @(posedge sys_clk_in) begin
        free_q <= !free_q;
        pme_q <= !pme_q;
        if (go_in) begin
            n_q <= BITS;
        end else if (n_q > 0) begin
            n_q <= n_q - 1;
        end
    end
    assign sec_clk_free_out = free_q;
    assign pme_n_out = pme_q;
    assign clk_mask_valid_out = (n_q != 0);
    // outside a frame the bit keeps changing so a stale value is never taken
    assign clk_mask_bit_out = (n_q != 0) ? pat_in[n_q-1] : free_q;
endmodule : brpc_far_model

// ===== brpc_checker_assertions.sv
`timescale 1ns/1ps
module brpc_checker #(
    parameter int HOLDOFF = 16
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic prim_reset_n_in,
    input wire logic sec_clock_stop_enable_in,
    input wire logic sec_clk_free_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic sec_reset_n_out,
    input wire logic secondary_clock_out,
    input wire logic prim_bus_oe_out,
    input wire logic sec_ctrl_oe_out,
    input wire logic [31:0] secondary_addr_data_out,
    input wire logic [3:0] secondary_cmd_byte_en_n_out,
    input wire logic secondary_parity_out,
    input wire logic buffer_flush_out
);
    // cycles since the primary pin went high; the refusal window only starts later
    int unsigned since_q;
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in || !prim_reset_n_in) begin
            since_q <= 0;
        end else if (since_q < 1000) begin
            since_q <= since_q + 1;
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    AST_PRIM_HOLDS_SEC: assert property (!prim_reset_n_in [*4] |=> !sec_reset_n_out)
        else $error("secondary reset released during primary reset");
    AST_PRIM_TRISTATE: assert property (!prim_reset_n_in [*4] |=> !prim_bus_oe_out && !sec_ctrl_oe_out)
        else $error("bus driven during primary reset");
    AST_HOLDOFF: assert property (pready_out && since_q < HOLDOFF |-> pslverr_out)
        else $error("access accepted inside hold-off");
    AST_SEC_CTRL_Z: assert property (!sec_reset_n_out |-> !sec_ctrl_oe_out)
        else $error("secondary controls driven in reset");
    AST_SEC_DATA_LOW: assert property (!sec_reset_n_out |-> secondary_addr_data_out == 32'h0
        && secondary_cmd_byte_en_n_out == 4'h0 && !secondary_parity_out)
        else $error("secondary data lines not low in reset");
    AST_FLUSH: assert property ($fell(sec_reset_n_out) |-> ##[0:2] buffer_flush_out)
        else $error("buffers not flushed on secondary reset");
    AST_CLK_RUNS: assert property ($past(reset_n_in) && !$past(sec_clock_stop_enable_in) |-> secondary_clock_out == $past(sec_clk_free_in))
        else $error("secondary clock stopped without enable");
    AST_REFUSED_ZERO: assert property (pready_out && pslverr_out |-> prdata_out == 32'h0)
        else $error("refused access returned data");
    AST_ANSWER: assert property (psel_in && !penable_in |=> pready_out ##1 !pready_out)
        else $error("access not answered in one cycle");
    COV_REFUSE: cover property (pready_out && pslverr_out);
    COV_SEC_RESET: cover property ($fell(sec_reset_n_out));
    COV_CLK_STOP: cover property (sec_clock_stop_enable_in && !secondary_clock_out [*4]);
endmodule : brpc_checker
bind brpc_top brpc_checker #(.HOLDOFF(HOLDOFF)) i_brpc_checker (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .prim_reset_n_in(prim_reset_n_in), .sec_clock_stop_enable_in(sec_clock_stop_enable_in),
    .sec_clk_free_in(sec_clk_free_in), .psel_in(psel_in), .penable_in(penable_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .sec_reset_n_out(sec_reset_n_out),
    .secondary_clock_out(secondary_clock_out), .prim_bus_oe_out(prim_bus_oe_out), .sec_ctrl_oe_out(sec_ctrl_oe_out),
    .secondary_addr_data_out(secondary_addr_data_out), .secondary_cmd_byte_en_n_out(secondary_cmd_byte_en_n_out),
    .secondary_parity_out(secondary_parity_out), .buffer_flush_out(buffer_flush_out));

// ===== bridge_reset_power_control_bench.sv
`timescale 1ns/1ps
module bridge_reset_power_control_bench;
    localparam int MB = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic prst_n = 1'b1;
    logic spin_n = 1'b1;
    logic stop_en = 1'b0;
    logic go = 1'b0;
    logic [15:0] pat = 16'h0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] pa = 12'h0;
    logic [31:0] pwd = 32'h0;
    logic free, mbit, mval, pme_n, rdy, err, srst_n, sclk, poe, scoe, par, flush, ev_n, led, e, t;
    logic [31:0] prd, ad, r;
    logic [3:0] cbe;
    logic [1:0] v, cur;
    logic [31:0] seed = 32'h5378;
    int error_cnt = 0;
    int cmp_count = 0;
    always #20 clk = !clk;
    brpc_far_model #(.BITS(MB)) i_brpc_far_model (.sys_clk_in(clk), .go_in(go), .pat_in(pat),
        .sec_clk_free_out(free), .clk_mask_bit_out(mbit), .clk_mask_valid_out(mval), .pme_n_out(pme_n));
    brpc_top #(.MASK_BITS(MB)) i_brpc_top (.sys_clk_in(clk), .reset_n_in(rst_n), .prim_reset_n_in(prst_n),
        .sec_reset_pin_n_in(spin_n), .sec_clock_stop_enable_in(stop_en), .clk_mask_bit_in(mbit),
        .clk_mask_valid_in(mval), .sec_clk_free_in(free), .pme_n_in(pme_n), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy), .pslverr_out(err),
        .sec_reset_n_out(srst_n), .secondary_clock_out(sclk), .prim_bus_oe_out(poe), .sec_ctrl_oe_out(scoe),
        .sec_data_oe_out(), .secondary_addr_data_out(ad), .secondary_cmd_byte_en_n_out(cbe),
        .secondary_parity_out(par), .buffer_flush_out(flush), .hot_swap_event_n_out(ev_n), .swap_ready_led_out(led));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // requests for the two unimplemented states leave the state alone
    function automatic logic [1:0] ps_next(input logic [1:0] c, input logic [1:0] w);
        return (w == brpc_pkg::PS_D1 || w == brpc_pkg::PS_D2) ? c : w;
    endfunction : ps_next
    task automatic report_and_stop();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        // no limit here: a missing answer is caught by the watchdog
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1);
        chk("pready wait", 32'h1, 32'(n));
        r = prd;
        e = err;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : acc
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (24) @(posedge clk);
        acc(1'b0, 12'h100, 32'h0);
        chk("unmapped", 32'h0, {r[31:1], r[0] | e});
        prst_n <= 1'b0;
        repeat (6) @(posedge clk);
        chk("srst prim", 32'h0, {30'h0, srst_n, poe | scoe});
        prst_n <= 1'b1;
        @(posedge clk);
        chk("srst held", 32'h0, 32'(srst_n));
        // the synchronised pin still holds the bridge for two edges; a setup there is never answered
        repeat (2) @(posedge clk);
        acc(1'b0, brpc_pkg::ADDR_CTRL, 32'h0);
        chk("holdoff", 32'h1, 32'(e));
        repeat (24) @(posedge clk);
        acc(1'b1, brpc_pkg::ADDR_CTRL, 32'h1);
        chk("after holdoff", 32'h0, 32'(e));
        repeat (2) @(posedge clk);
        chk("sec bit", 32'h1, {ad[30:0] | cbe | par | scoe, flush & !srst_n});
        acc(1'b0, brpc_pkg::ADDR_CTRL, 32'h0);
        chk("read in sec reset", 32'h1, {r[31:1], r[0] & !e});
        acc(1'b1, brpc_pkg::ADDR_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk("sec bit clear", 32'h1, 32'(srst_n));
        spin_n <= 1'b0;
        repeat (4) @(posedge clk);
        chk("pin reset", 32'h0, ad | 32'(cbe) | 32'(par) | 32'(scoe));
        spin_n <= 1'b1;
        repeat (4) @(posedge clk);
        stop_en <= 1'b1;
        cur = brpc_pkg::PS_D0;
        for (int i = 0; i < 10; i++) begin
            v = (i < 4) ? 2'(8'h9C >> (2 * i)) : 2'(rnd());
            acc(1'b1, brpc_pkg::ADDR_PMCSR, 32'(v));
            acc(1'b0, brpc_pkg::ADDR_PMCSR, 32'h0);
            cur = ps_next(cur, v);
            chk("power state", 32'(cur), {30'h0, r[1:0]});
            repeat (2) @(posedge clk);
            t = sclk;
            @(posedge clk);
            chk("sec clock", (cur == brpc_pkg::PS_D3HOT) ? 32'h0 : 32'h1, 32'(t ^ sclk));
            chk("no sec reset", 32'h1, 32'(srst_n));
        end
        stop_en <= 1'b0;
        pat <= 16'(rnd());
        acc(1'b1, brpc_pkg::ADDR_DIAG, 32'h1);
        repeat (2) @(posedge clk);
        chk("chip reset", 32'h0, {30'h0, srst_n, poe});
        acc(1'b0, brpc_pkg::ADDR_CTRL, 32'h0);
        chk("chip refuse", 32'h1, 32'(e));
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (MB + 4) @(posedge clk);
        chk("held for bit", 32'h0, 32'(srst_n));
        acc(1'b1, brpc_pkg::ADDR_CTRL, 32'h0);
        repeat (brpc_pkg::CHIP_RST_CLEAR_MAX_CLKS) @(posedge clk);
        acc(1'b0, brpc_pkg::ADDR_DIAG, 32'h0);
        chk("chip clear", 32'h0, {r[0], e});
        acc(1'b0, brpc_pkg::ADDR_STATUS, 32'h0);
        chk("mask loaded", 32'h3, {r[16], srst_n});
        chk("mask value", 32'(pat[MB-1:0]), 32'(r[MB-1:0]));
        acc(1'b1, brpc_pkg::ADDR_HOTSWAP, 32'h1);
        // the pin flop follows the register one edge later
        @(posedge clk);
        chk("event set", 32'h0, 32'(ev_n));
        acc(1'b1, brpc_pkg::ADDR_HOTSWAP, 32'h6);
        @(posedge clk);
        chk("event clear led", 32'h3, {ev_n, led});
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk("mid reset", 32'h1, {srst_n, flush});
        rst_n <= 1'b1;
        repeat (24) @(posedge clk);
        report_and_stop();
    end
endmodule : bridge_reset_power_control_bench
